// ==== design/cell_memory_command_port.v ====
// Command sequencer and configuration word of the cell switching memory
`timescale 1ns/1ns
`include "cell_cmd_map.vh"
// Operation
// RULE1: Store command runs a four-cycle write of input cell buffer.
// RULE2: Controller gives store command once per memory store cycle.
// RULE3: Header edit step may be pre/post-pend or header-CRC edit instead.
// RULE4: Store address phase carries cell address, device select, five edit bits.
// RULE5: Load command runs a four-cycle copy into output cell buffer.
// RULE6: Controller gives load command once per load sequence.
// RULE7: Output header edit may be output pre/post-pend or header-CRC edit.
// RULE8: Load address phase carries cell and device address; edit bits ignored.
// RULE9: Refresh starts on command, ends after four-cycle memory refresh.
// RULE10: Controller holds refresh one cycle, no other command until done.
// RULE11: Configuration bits map one-to-one onto data bus lines.
// RULE12: Bits 0-3 input grouping code, bits 4-7 output grouping code.
// RULE13: Bits 8-10 input start, bits 11-16 input stop byte.
// RULE14: Bits 17-19 output start, bits 20-25 output stop byte.
// RULE15: Bits 26-29 chip address selecting this device.
// RULE16: Bit 30 not stored; high resets status and output-waiting bits.
// RULE17: Bit 31 enables control interface outputs.
// RULE18: Grouped ports use group clock and frame pins.
// RULE19: Grouped ports take clock and frame of lowest pin.
// RULE20: Five top bus bits on store clear or protect first edit word.
// RULE21: Controller holds chip select low for whole sequence.
// RULE22: New command accepted only after current memory cycle completes; edit commands and the bit 30 status clear still act while busy.
module cell_memory_command_port
#(
    parameter PORTS = 8
)
(
    input  wire                 clk_sys,
    input  wire                 rst,
    input  wire                 chipSel_n,
    input  wire [`CMD_W-1:0]    cmdCode,
    input  wire [31:0]          busIn,
    input  wire [PORTS-1:0]     outWaitSet,
    output reg  [31:0]          busOut_ff,
    output reg                  busOe_n_ff,
    output reg                  memWrite_ff,
    output reg                  memRead_ff,
    output reg                  memRefresh_ff,
    output reg                  busy_ff,
    output reg  [12:0]          cellAddr_ff,
    output reg  [4:0]           editCtl_ff,
    output reg  [2:0]           editKind_ff,
    output reg                  editStrobe_ff,
    output reg                  editOutput_ff,
    output reg  [31:0]          cfgWord_ff,
    output reg  [PORTS*3-1:0]   rxClkSel_ff,
    output reg  [PORTS*3-1:0]   txClkSel_ff,
    output reg  [PORTS-1:0]     outWait_ff,
    output reg                  ctlOutEn_ff
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam ST_IDLE  = 4'b0001;
    localparam ST_STORE = 4'b0010;
    localparam ST_LOAD  = 4'b0100;
    localparam ST_REF   = 4'b1000;

    reg  [3:0]          state_ff;
    reg  [3:0]          nxt_state;
    reg  [2:0]          cnt_ff;
    reg  [2:0]          nxt_cnt;
    reg  [31:0]         busSync1_ff;
    reg  [31:0]         busSync2_ff;
    reg  [`CMD_W-1:0]   cmdSync1_ff;
    reg  [`CMD_W-1:0]   cmdSync2_ff;
    reg                 csSync1_ff;
    reg                 csSync2_ff;
    wire [PORTS*3-1:0]  rxSel;
    wire [PORTS*3-1:0]  txSel;
    wire [3:0]          devSel;
    wire                selected;
    wire                idle;
    wire                statusClr;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busSync1_ff <= 32'h00000000;
            busSync2_ff <= 32'h00000000;
            cmdSync1_ff <= `CMD_NOP;
            cmdSync2_ff <= `CMD_NOP;
            csSync1_ff  <= 1'b1;
            csSync2_ff  <= 1'b1;
        end
        else
        begin
            busSync1_ff <= busIn;
            busSync2_ff <= busSync1_ff;
            cmdSync1_ff <= cmdCode;
            cmdSync2_ff <= cmdSync1_ff;
            csSync1_ff  <= chipSel_n;
            csSync2_ff  <= csSync1_ff;
        end
    end

    // RULE21: chip select gates commands
    assign selected = ~csSync2_ff;
    assign idle     = (state_ff == ST_IDLE);
    assign devSel   = busSync2_ff[`AP_DEV_HI:`AP_DEV_LO];
    // RULE16: reset bit on config write
    assign statusClr = selected && (cmdSync2_ff == `CMD_CONFIG)
                       && busSync2_ff[`CFG_RESET_BIT];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @*
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                // RULE22: accept only while idle
                if (selected && devSel == cfgWord_ff[`CFG_ADDR_HI:`CFG_ADDR_LO])
                begin
                    case (cmdSync2_ff)
                        `CMD_STORE:   nxt_state = ST_STORE;
                        `CMD_LOAD:    nxt_state = ST_LOAD;
                        default:      nxt_state = ST_IDLE;
                    endcase
                end
                if (selected && cmdSync2_ff == `CMD_REFRESH)
                    nxt_state = ST_REF;
                if (nxt_state != ST_IDLE)
                    nxt_cnt = `MEM_CYCLES - 3'h1;
            end
            // RULE1: four store cycles
            // RULE5: four load cycles
            // RULE9: four refresh cycles
            ST_STORE, ST_LOAD, ST_REF:
            begin
                if (cnt_ff == 3'h0)
                    nxt_state = ST_IDLE;
                else
                    nxt_cnt = cnt_ff - 3'h1;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_ff      <= ST_IDLE;
            cnt_ff        <= 3'h0;
            memWrite_ff   <= 1'b0;
            memRead_ff    <= 1'b0;
            memRefresh_ff <= 1'b0;
            busy_ff       <= 1'b0;
            cellAddr_ff   <= 13'h0000;
            editCtl_ff    <= 5'h00;
        end
        else
        begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            memWrite_ff   <= (nxt_state == ST_STORE);
            memRead_ff    <= (nxt_state == ST_LOAD);
            memRefresh_ff <= (nxt_state == ST_REF);
            busy_ff       <= (nxt_state != ST_IDLE);
            if (idle && (nxt_state == ST_STORE || nxt_state == ST_LOAD))
                cellAddr_ff <= busSync2_ff[`AP_CELL_HI:`AP_CELL_LO];
            // RULE4: edit bits taken on store
            // RULE20: top five bits select edits
            // RULE8: load leaves edit bits alone
            if (idle && nxt_state == ST_STORE)
                editCtl_ff <= busSync2_ff[`AP_EDIT_HI:`AP_EDIT_LO];
        end
    end

    // ------------------------------------------------------------
    // Edit commands
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            editKind_ff   <= 3'h0;
            editStrobe_ff <= 1'b0;
            editOutput_ff <= 1'b0;
        end
        else
        begin
            editStrobe_ff <= 1'b0;
            if (selected)
            begin
                case (cmdSync2_ff)
                    // RULE3: input edit alternatives
                    `CMD_IHE, `CMD_IPPE, `CMD_IHCE:
                    begin
                        editKind_ff   <= cmdSync2_ff[2:0];
                        editStrobe_ff <= 1'b1;
                        editOutput_ff <= 1'b0;
                    end
                    // RULE7: output edit alternatives
                    `CMD_OHE, `CMD_OPPE, `CMD_OHCE:
                    begin
                        editKind_ff   <= cmdSync2_ff[2:0];
                        editStrobe_ff <= 1'b1;
                        editOutput_ff <= 1'b1;
                    end
                    default: editStrobe_ff <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration word
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cfgWord_ff  <= `CFG_RESET_VAL;
            ctlOutEn_ff <= 1'b0;
        end
        else if (selected && idle && cmdSync2_ff == `CMD_CONFIG)
        begin
            // RULE11: bit-for-bit copy except bit 30, stored as zero
            // RULE12: grouping codes
            // RULE13: input start and stop
            // RULE14: output start and stop
            // RULE15: chip address
            cfgWord_ff <= {busSync2_ff[31], 1'b0, busSync2_ff[29:0]};
            // RULE17: control output enable
            ctlOutEn_ff <= busSync2_ff[`CFG_CONTROL_OUTPUT_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Status and output-waiting bits
    // ------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            outWait_ff <= {PORTS{1'b0}};
        else
            // Set wins over clear so no event is lost
            outWait_ff <= (statusClr ? {PORTS{1'b0}} : outWait_ff) | outWaitSet;
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busOut_ff  <= 32'h00000000;
            busOe_n_ff <= 1'b1;
        end
        else
        begin
            busOut_ff  <= {{(32-PORTS){1'b0}}, outWait_ff};
            // Drive only when enabled, chip-selected and idle, so parallel parts share the bus
            busOe_n_ff <= ~(ctlOutEn_ff && selected && idle);
        end
    end

    // ------------------------------------------------------------
    // Port grouping
    // ------------------------------------------------------------
    // RULE18: group clock/frame pins
    // RULE19: lowest pin of group
    clk_group_select #(.PORTS(PORTS)) rxGroup
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .groupCode (cfgWord_ff[`CFG_IGRP_HI:`CFG_IGRP_LO]),
        .srcSel_ff (rxSel)
    );

    clk_group_select #(.PORTS(PORTS)) txGroup
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .groupCode (cfgWord_ff[`CFG_OGRP_HI:`CFG_OGRP_LO]),
        .srcSel_ff (txSel)
    );

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rxClkSel_ff <= {PORTS*3{1'b0}};
            txClkSel_ff <= {PORTS*3{1'b0}};
        end
        else
        begin
            rxClkSel_ff <= rxSel;
            txClkSel_ff <= txSel;
        end
    end
endmodule

// ==== design/cell_cmd_map.vh ====
// Constants for the cell memory command port
`ifndef CELL_CMD_MAP_VH
`define CELL_CMD_MAP_VH
// Command codes on the command bus
`define CMD_W          4
`define CMD_NOP        4'h0
`define CMD_STORE      4'h1
`define CMD_LOAD       4'h2
`define CMD_REFRESH    4'h3
`define CMD_CONFIG     4'h4
`define CMD_IHE        4'h5
`define CMD_IPPE       4'h6
`define CMD_IHCE       4'h7
`define CMD_OHE        4'h8
`define CMD_OPPE       4'h9
`define CMD_OHCE       4'ha
// Memory cycle length
`define MEM_CYCLES     3'h4
// Configuration word fields
`define CFG_IGRP_LO    0
`define CFG_IGRP_HI    3
`define CFG_OGRP_LO    4
`define CFG_OGRP_HI    7
`define CFG_ISTA_LO    8
`define CFG_ISTA_HI    10
`define CFG_ISTO_LO    11
`define CFG_ISTO_HI    16
`define CFG_OSTA_LO    17
`define CFG_OSTA_HI    19
`define CFG_OSTO_LO    20
`define CFG_OSTO_HI    25
`define CFG_ADDR_LO    26
`define CFG_ADDR_HI    29
`define CFG_RESET_BIT  30
`define CFG_CONTROL_OUTPUT_ENABLE_BIT  31
`define CFG_RESET_VAL  32'h00000000
// Address phase fields
`define AP_CELL_LO     0
`define AP_CELL_HI     12
`define AP_DEV_LO      13
`define AP_DEV_HI      16
`define AP_EDIT_LO     27
`define AP_EDIT_HI     31
`endif

// ==== design/clk_group_select.v ====
// Per-port clock/frame selector for port grouping
`timescale 1ns/1ns
module clk_group_select
#(
    parameter PORTS = 8
)
(
    input  wire              clk_sys,
    input  wire              rst,
    input  wire [3:0]        groupCode,
    output reg  [PORTS*3-1:0] srcSel_ff
)
;
    reg [PORTS*3-1:0] nxt_srcSel;
    integer           p;
    reg [2:0]         s;

    always @*
    begin
        nxt_srcSel = {PORTS*3{1'b0}};
        for (p = 0; p < PORTS; p = p + 1)
        begin
            s = p[2:0];
            case (groupCode)
                4'h1: if (p < 2) s = 3'h0;
                4'h2: if (p >= 6) s = 3'h6;
                4'h3: if (p < 4) s = {1'b0, p[1], 1'b0};
                4'h4: if (p >= 4) s = {1'b1, p[1], 1'b0};
                4'h5: if (p < 6) s = {p[2], p[1], 1'b0};
                4'h6: if (p >= 2) s = {p[2], p[1], 1'b0};
                4'h7: s = {p[2], p[1], 1'b0};
                4'h8: if (p >= 4) s = 3'h4;
                4'h9: if (p < 4) s = 3'h0;
                4'ha: if (p >= 4) s = 3'h4; else if (p >= 2) s = 3'h2;
                4'hb: if (p < 4) s = 3'h0; else if (p < 6) s = 3'h4;
                4'hc: if (p >= 4) s = 3'h4; else s = {1'b0, p[1], 1'b0};
                4'hd: if (p < 4) s = 3'h0; else s = {1'b1, p[1], 1'b0};
                4'he: s = {p[2], 2'b00};
                4'hf: s = 3'h0;
                default: s = p[2:0];
            endcase
            nxt_srcSel[p*3 +: 3] = s;
        end
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            srcSel_ff <= {PORTS*3{1'b0}};
        else
            srcSel_ff <= nxt_srcSel;
    end
endmodule

// ==== testbench/cell_memory_command_port_properties.sv ====
// Timing properties of the cell memory command port
`timescale 1ns/1ns
module cell_memory_command_port_properties
(
    input wire        clk_sys,
    input wire        rst,
    input wire        memWrite_ff,
    input wire        memRead_ff,
    input wire        memRefresh_ff,
    input wire        busy_ff,
    input wire [12:0] cellAddr_ff,
    input wire [4:0]  editCtl_ff,
    input wire [31:0] cfgWord_ff,
    input wire        ctlOutEn_ff,
    input wire        busOe_n_ff
);
// ----
// Properties
// ----
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);
property p_write; $rose(memWrite_ff) |-> memWrite_ff[*4] ##1 !memWrite_ff; endproperty
a_write: assert property (p_write) else $error("store cycle length wrong");
property p_read; $rose(memRead_ff) |-> memRead_ff[*4] ##1 !memRead_ff; endproperty
a_read: assert property (p_read) else $error("load cycle length wrong");
property p_refresh; $rose(memRefresh_ff) |-> memRefresh_ff[*4] ##1 !memRefresh_ff; endproperty
a_refresh: assert property (p_refresh) else $error("refresh length wrong");
property p_busy; $rose(busy_ff) |-> busy_ff[*4] ##1 !busy_ff; endproperty
a_busy: assert property (p_busy) else $error("busy length wrong");
property p_excl;
    $onehot0({memWrite_ff, memRead_ff, memRefresh_ff})
    && ((memWrite_ff | memRead_ff | memRefresh_ff) == busy_ff);
endproperty
a_excl: assert property (p_excl) else $error("overlapping memory cycles");
property p_addr; busy_ff && $past(busy_ff) |-> $stable(cellAddr_ff); endproperty
a_addr: assert property (p_addr) else $error("cell address moved mid cycle");
property p_edit; !$rose(memWrite_ff) |-> $stable(editCtl_ff); endproperty
a_edit: assert property (p_edit) else $error("edit bits changed outside store");
property p_control_output_enable; ctlOutEn_ff == cfgWord_ff[31]; endproperty
a_control_output_enable: assert property (p_control_output_enable) else $error("control enable not bit 31");
property p_bit30; !cfgWord_ff[30]; endproperty
a_bit30: assert property (p_bit30) else $error("bit 30 was stored");
property p_oe; !ctlOutEn_ff && !$past(ctlOutEn_ff) |-> busOe_n_ff; endproperty
a_oe: assert property (p_oe) else $error("bus driven while disabled");
c_write: cover property ($rose(memWrite_ff));
c_read: cover property ($rose(memRead_ff));
c_refresh: cover property ($rose(memRefresh_ff));
endmodule
bind cell_memory_command_port cell_memory_command_port_properties chk (
    .clk_sys(clk_sys), .rst(rst), .memWrite_ff(memWrite_ff), .memRead_ff(memRead_ff),
    .memRefresh_ff(memRefresh_ff), .busy_ff(busy_ff), .cellAddr_ff(cellAddr_ff),
    .editCtl_ff(editCtl_ff), .cfgWord_ff(cfgWord_ff), .ctlOutEn_ff(ctlOutEn_ff),
    .busOe_n_ff(busOe_n_ff));

// ==== testbench/queue_ctl_model.sv ====
// Queue controller model driving the command port
`timescale 1ns/1ns
module queue_ctl_model
(
    input  wire        clk_sys,
    output reg         chipSel_n,
    output reg  [3:0]  cmdCode,
    output reg  [31:0] busIn
);
// ----
// Command issue
// ----
initial
begin
    chipSel_n = 1'h1;
    cmdCode = 4'h0;
    busIn = 32'h00000000;
end
task automatic issue(input [3:0] c, input [31:0] d);
begin
    @(posedge clk_sys);
    #1;
    chipSel_n = 1'h0;
    cmdCode = c;
    busIn = d;
    @(posedge clk_sys);
    #1;
    cmdCode = 4'h0;
    // Inverted idle data so stale values cannot pass
    busIn = ~d;
end
endtask
endmodule

// ==== testbench/tb_cell_memory_command_port.sv ====
// Self-checking bench for the cell memory command port
`timescale 1ns/1ns
`include "cell_cmd_map.vh"
module tb_cell_memory_command_port;
reg         clk_sys;
reg         rst;
reg  [7:0]  outWaitSet;
wire        chipSel_n, busOe_n_ff, memWrite_ff, memRead_ff, memRefresh_ff;
wire        busy_ff, editStrobe_ff, editOutput_ff, ctlOutEn_ff;
wire [3:0]  cmdCode;
wire [31:0] busIn, busOut_ff, cfgWord_ff;
wire [12:0] cellAddr_ff;
wire [4:0]  editCtl_ff;
wire [2:0]  editKind_ff;
wire [23:0] rxClkSel_ff, txClkSel_ff;
wire [7:0]  outWait_ff;
integer     errTotal = 0;
integer     checked = 0;
integer     cycles = 0;
reg  [31:0] nb;
reg  [2:0]  fl;
localparam [31:0] CFG = {1'h1, 1'h0, 4'h5, 6'h34, 3'h2, 6'h35, 3'h3, 4'hf, 4'h0};
queue_ctl_model model (.clk_sys(clk_sys), .chipSel_n(chipSel_n), .cmdCode(cmdCode),
    .busIn(busIn));
cell_memory_command_port #(.PORTS(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .chipSel_n(chipSel_n), .cmdCode(cmdCode),
    .busIn(busIn), .outWaitSet(outWaitSet), .busOut_ff(busOut_ff),
    .busOe_n_ff(busOe_n_ff), .memWrite_ff(memWrite_ff), .memRead_ff(memRead_ff),
    .memRefresh_ff(memRefresh_ff), .busy_ff(busy_ff), .cellAddr_ff(cellAddr_ff),
    .editCtl_ff(editCtl_ff), .editKind_ff(editKind_ff), .editStrobe_ff(editStrobe_ff),
    .editOutput_ff(editOutput_ff), .cfgWord_ff(cfgWord_ff), .rxClkSel_ff(rxClkSel_ff),
    .txClkSel_ff(txClkSel_ff), .outWait_ff(outWait_ff), .ctlOutEn_ff(ctlOutEn_ff));
// ----
// Shared tasks
// ----
task chk(input string nm, input [31:0] got, input [31:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        errTotal = errTotal + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
end
endtask
// Counts busy cycles and memory strobes seen over ten edges
task mem_op(input [3:0] c, input [31:0] d);
begin
    model.issue(c, d);
    nb = 32'h0;
    fl = 3'h0;
    repeat (10)
    begin
        @(posedge clk_sys);
        #1;
        nb = nb + busy_ff;
        fl = fl | {memRefresh_ff, memRead_ff, memWrite_ff};
    end
end
endtask
task complete_run;
begin
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
end
endtask
// ----
// Scenarios
// ----
task t_config;
begin
    model.issue(`CMD_CONFIG, CFG);
    repeat (6) @(posedge clk_sys);
    #1;
    chk("cfgWord", cfgWord_ff, CFG);
    chk("ctlOutEn", ctlOutEn_ff, 1);
    chk("busOe_n", busOe_n_ff, 0);
    chk("rxClkSel", rxClkSel_ff, 24'hfac688);
    chk("txClkSel", txClkSel_ff, 24'h000000);
    // Paired and mixed groupings, input and output set apart
    model.issue(`CMD_CONFIG, {CFG[31:8], 4'ha, 4'h5});
    repeat (6) @(posedge clk_sys);
    #1;
    chk("rxClkSel", rxClkSel_ff, 24'hfa4480);
    chk("txClkSel", txClkSel_ff, 24'h924488);
    $display("test config done");
end
endtask
task t_store;
begin
    mem_op(`CMD_STORE, {5'h15, 10'h000, 4'h5, 13'h1abc});
    chk("busyCount", nb, 4);
    chk("memFlags", fl, 3'h1);
    chk("cellAddr", cellAddr_ff, 13'h1abc);
    chk("editCtl", editCtl_ff, 5'h15);
    // Load lands while the store is still busy and must be dropped
    model.issue(`CMD_STORE, {5'h0a, 10'h000, 4'h5, 13'h0123});
    mem_op(`CMD_LOAD, {5'h00, 10'h000, 4'h5, 13'h0456});
    chk("busyCount", nb, 3);
    chk("memFlags", fl, 3'h1);
    chk("cellAddr", cellAddr_ff, 13'h0123);
    $display("test store done");
end
endtask
task t_load;
begin
    mem_op(`CMD_LOAD, {5'h1f, 10'h000, 4'h5, 13'h0777});
    chk("busyCount", nb, 4);
    chk("memFlags", fl, 3'h2);
    chk("cellAddr", cellAddr_ff, 13'h0777);
    chk("editCtl", editCtl_ff, 5'h0a);
    mem_op(`CMD_STORE, {5'h00, 10'h000, 4'h3, 13'h0001});
    chk("busyCount", nb, 0);
    chk("cellAddr", cellAddr_ff, 13'h0777);
    $display("test load done");
end
endtask
task t_refresh;
begin
    mem_op(`CMD_REFRESH, 32'h00006000);
    chk("busyCount", nb, 4);
    chk("memFlags", fl, 3'h4);
    $display("test refresh done");
end
endtask
task t_edit;
    integer k;
    integer w;
    reg     seen;
begin
    for (k = 5; k <= 10; k = k + 1)
    begin
        model.issue(k[3:0], 32'hffffffff);
        seen = 1'h0;
        for (w = 0; w < 8 && !seen; w = w + 1)
        begin
            @(posedge clk_sys);
            #1;
            seen = (editStrobe_ff === 1'h1);
        end
        chk("editStrobe", seen, 1);
        chk("editKind", editKind_ff, k[2:0]);
        chk("editOutput", editOutput_ff, k >= 8);
    end
    $display("test edit done");
end
endtask
task t_wait_clear;
begin
    outWaitSet = 8'h24;
    @(posedge clk_sys);
    #1;
    outWaitSet = 8'h00;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("outWait", outWait_ff, 8'h24);
    chk("busOut", busOut_ff[7:0], 8'h24);
    model.issue(`CMD_CONFIG, CFG | 32'h40000000);
    repeat (6) @(posedge clk_sys);
    #1;
    chk("outWait", outWait_ff, 8'h00);
    chk("busOut", busOut_ff[7:0], 8'h00);
    chk("cfgWord", cfgWord_ff, CFG);
    $display("test wait clear done");
end
endtask
// ----
// Clock, watchdog and main sequence
// ----
initial
begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
end
always @(posedge clk_sys)
begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
        errTotal = errTotal + 1;
        complete_run;
    end
end
initial
begin
    rst = 1'h1;
    outWaitSet = 8'h00;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'h0;
    t_config;
    t_store;
    t_load;
    t_refresh;
    t_edit;
    t_wait_clear;
    complete_run;
end
endmodule
